/* File: rtl/lpm_pkg.sv */
// constants and types shared by the link power, error and lock manager
`default_nettype none
package lpm_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	// register byte offsets
	localparam logic [7:0] REG_VIDEO_CFG    = 8'h00;
	localparam logic [7:0] REG_ERR_CFG      = 8'h01;
	localparam logic [7:0] REG_POWER        = 8'h04;
	localparam logic [7:0] REG_PAR_LIM_LO   = 8'h08;
	localparam logic [7:0] REG_PAR_LIM_HI   = 8'h09;
	localparam logic [7:0] REG_PAR_CNT_LO   = 8'h0A;
	localparam logic [7:0] REG_PAR_CNT_HI   = 8'h0B;
	localparam logic [7:0] REG_PRBS_CNT     = 8'h0C;
	localparam logic [7:0] REG_UART_ERR     = 8'h0D;
	localparam logic [7:0] REG_RATE         = 8'h0E;
	// field positions
	localparam int unsigned PARITY_EN_BIT   = 3;
	localparam int unsigned AUTO_CLR_BIT    = 5;
	localparam int unsigned POWER_DOWN_BIT  = 4;
	localparam int unsigned SER_EN_BIT      = 3;
	localparam int unsigned PATTERN_EN_BIT  = 0;
	localparam int unsigned RATE_HI_BIT     = 1;
	// reset values
	localparam logic [15:0] PAR_LIM_RST     = 16'hFFFF;
	localparam logic [22:0] PRBS_SEED       = 23'h7FFFFF;
	// error frame bits: frame, parity, packet, i2c
	localparam int unsigned ERRF_W          = 4;
	// timing
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned WAKE_WINDOW_MS  = 70;
	localparam int unsigned WAKE_CYC        = WAKE_WINDOW_MS * CLK_MHZ * 1000;
	localparam int unsigned PLL_LOCK_CYC    = 32768;
	localparam int unsigned SHORT_LEN_LO    = 546;
	localparam int unsigned SHORT_LEN_HI    = 1090;
	localparam int unsigned LONG_LEN        = 17410;
	localparam int unsigned SYNC_FAIL_MAX   = 62;
	localparam int unsigned HSK_WAIT_CYC    = 64;
	localparam int unsigned DEC_ERR_LIMIT   = 16;
	localparam int unsigned TMR_W           = 25;

	typedef struct packed {
		logic       parity_en;
		logic       auto_error_clear;
		logic       power_down_bit;
		logic       serialization_enable;
		logic       pattern_test_enable;
		logic [1:0] pixel_rate_range;
	} lpm_cfg_t;

	typedef enum logic [7:0] {
		ST_BOOT  = 8'h01,
		ST_OFF   = 8'h02,
		ST_WAKE  = 8'h04,
		ST_CTRL  = 8'h08,
		ST_PLLW  = 8'h10,
		ST_HSK   = 8'h20,
		ST_SYNC  = 8'h40,
		ST_VIDEO = 8'h80
	} lpm_state_t;
endpackage
`default_nettype wire

/* File: rtl/lpm_link_manager.sv */
// link power sequencing, error reporting and lock handshake
// Notes on behaviour
// - grounded strap: power up with power-down clear and serialization enabled
// - local: stay in channel without clock, then lock interval before handshake
// - clock present at local power-up: serialization starts after PLL lock
// - after wake frame, power-down must clear within 70ms or sleep again
// - remote start: serialization enable is 0, timers idle, channel stays open
// - host writing power-down in open channel powers down; full wake needed
// - error output pulled low while uart, parity or prbs error pending
// - uart errors recorded; error frame only on closing frame
// - error frame stored in uart error register; unreported while unlocked
// - reading uart error register clears it, error output follows at once
// - parity errors counted in 16-bit counter split over two bytes
// - outside bypass or with auto clear, parity count at or over limit flags error until next video phase
// - auto clear wipes parity and uart errors at channel end, not prbs
// - without auto clear, errors clear on read and keep accumulating
// - prbs mismatches counted; error while nonzero; disabling test clears
// - lock frame received: short pattern, 546 or 1090 words by rate range
// - power-up or no lock frame: long pattern of 17410 words
// - remote: 62 failed attempts clear serialization enable; local retries
// - lock frame sent only if decode errors stayed under limit, else unlock
// - in channel the recovered data outputs hold their last video values
// - lock and channel flags encode video, channel and loss of lock
`timescale 1ns/1ps
`default_nettype none
module lpm_link_manager
	import lpm_pkg::*;
#(
	parameter int unsigned WORD_W     = 18,
	parameter int unsigned WAKE_LIM   = WAKE_CYC,
	parameter int unsigned PLLW_LIM   = PLL_LOCK_CYC,
	parameter int unsigned HSK_LIM    = HSK_WAIT_CYC,
	parameter int unsigned DEC_LIM    = DEC_ERR_LIMIT
) (
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              remote_wake_select_i,
	input  wire logic              pclk_present_i,
	input  wire logic              dummy_frame_i,
	input  wire logic              vsync_edge_i,
	input  wire logic              chan_timeout_i,
	input  wire logic              closing_frame_i,
	input  wire logic              bypass_mode_i,
	input  wire logic              lock_frame_rx_i,
	input  wire logic              sync_ok_i,
	input  wire logic              decode_err_i,
	input  wire logic [ERRF_W-1:0] ser_uart_err_i,
	input  wire logic [ERRF_W-1:0] des_uart_err_i,
	input  wire logic              i2c_enable_i,
	input  wire logic              parity_err_i,
	input  wire logic              word_valid_i,
	input  wire logic [WORD_W-1:0] word_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic                   low_power_o,
	output logic                   timers_enable_o,
	output logic                   control_phase_active_o,
	output logic                   lock_oe_o,
	output logic                   lock_frame_tx_o,
	output logic                   sync_active_o,
	output logic                   sync_long_o,
	output logic                   error_oe_o,
	output logic      [WORD_W-1:0] word_o
);
	localparam logic [TMR_W-1:0] WAKE_END  = TMR_W'(WAKE_LIM - 1);
	localparam logic [TMR_W-1:0] PLLW_END  = TMR_W'(PLLW_LIM - 1);
	localparam logic [TMR_W-1:0] HSK_END   = TMR_W'(HSK_LIM - 1);
	localparam logic [TMR_W-1:0] LONG_END  = TMR_W'(LONG_LEN - 1);
	localparam logic [TMR_W-1:0] SHLO_END  = TMR_W'(SHORT_LEN_LO - 1);
	localparam logic [TMR_W-1:0] SHHI_END  = TMR_W'(SHORT_LEN_HI - 1);
	localparam logic [5:0]       FAIL_END  = 6'(SYNC_FAIL_MAX - 1);
	localparam logic [7:0]       DEC_END   = 8'(DEC_LIM);

	// sequencer state
	lpm_state_t       state, next_state;
	logic [TMR_W-1:0] tmr, next_tmr;
	logic [5:0]       fails, next_fails;
	logic             remote, next_remote;
	logic             pll_ok, next_pll_ok;
	logic             long_seq, next_long_seq;
	logic             lock, next_lock;
	logic             lock_tx, next_lock_tx;
	logic             control_phase_active, next_control_phase_active;
	logic [7:0]       dec_cnt, next_dec_cnt;
	logic [WORD_W-1:0] word_q, next_word_q;
	// sequencer events seen by the other groups
	logic             boot_remote;
	logic             serialization_enable_clr;
	logic             ch_open;
	logic             ch_end;
	logic             video_start;
	logic [TMR_W-1:0] sync_end;

	// register and error state
	lpm_cfg_t         cfg, next_cfg;
	logic [15:0]      par_lim, next_par_lim;
	logic [15:0]      par_cnt, next_par_cnt;
	logic [7:0]       prbs_cnt, next_prbs_cnt;
	logic [22:0]      lfsr, next_lfsr;
	logic [ERRF_W-1:0] ser_err, next_ser_err;
	logic [7:0]       uart_flags, next_uart_flags;
	logic             par_flag, next_par_flag;
	logic             err_q, next_err_q;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic             wr_ok;
	logic             err_frame;

	assign sync_end = long_seq ? LONG_END :
		(cfg.pixel_rate_range[RATE_HI_BIT] ? SHHI_END : SHLO_END);

	always_comb begin
		next_state    = state;
		next_tmr      = tmr;
		next_fails    = fails;
		next_remote   = remote;
		next_pll_ok   = pll_ok;
		next_long_seq = long_seq;
		next_lock     = lock;
		next_lock_tx  = 1'b0;
		next_dec_cnt  = dec_cnt;
		next_word_q   = word_q;
		boot_remote   = 1'b0;
		serialization_enable_clr     = 1'b0;
		ch_open       = 1'b0;
		ch_end        = 1'b0;
		video_start   = 1'b0;
		unique case (state)
			ST_BOOT: begin
				// strap caught on the first clocked edge after release
				next_remote = remote_wake_select_i;
				if (remote_wake_select_i) begin
					boot_remote = 1'b1;
					next_state  = ST_OFF;
				end else if (pclk_present_i) begin
					next_tmr   = '0;
					next_state = ST_PLLW;
				end else begin
					next_state = ST_CTRL;
				end
			end
			ST_OFF: begin
				if (dummy_frame_i) begin
					next_tmr   = '0;
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (!cfg.power_down_bit) begin
					next_state = ST_CTRL;
				end else if (tmr == WAKE_END) begin
					next_state = ST_OFF;
				end else begin
					next_tmr = tmr + 1'b1;
				end
			end
			ST_CTRL: begin
				if (cfg.power_down_bit) begin
					next_state  = ST_OFF;
					next_pll_ok = 1'b0;
				end else if (cfg.serialization_enable && pclk_present_i &&
					(chan_timeout_i || (closing_frame_i && !bypass_mode_i))) begin
					// with enable clear the channel never closes
					ch_end = 1'b1;
					if (lock && dec_cnt < DEC_END) begin
						next_lock_tx = 1'b1;
					end else begin
						next_lock = 1'b0;
					end
					next_tmr   = '0;
					next_state = pll_ok ? ST_HSK : ST_PLLW;
				end
			end
			ST_PLLW: begin
				if (!pclk_present_i) begin
					next_state = ST_CTRL;
				end else if (tmr == PLLW_END) begin
					next_pll_ok = 1'b1;
					next_tmr    = '0;
					next_state  = ST_HSK;
				end else begin
					next_tmr = tmr + 1'b1;
				end
			end
			ST_HSK: begin
				if (lock_frame_rx_i) begin
					next_long_seq = 1'b0;
					next_tmr      = '0;
					next_state    = ST_SYNC;
				end else if (tmr == HSK_END) begin
					next_long_seq = 1'b1;
					next_tmr      = '0;
					next_state    = ST_SYNC;
				end else begin
					next_tmr = tmr + 1'b1;
				end
			end
			ST_SYNC: begin
				if (tmr != sync_end) begin
					next_tmr = tmr + 1'b1;
				end else if (sync_ok_i) begin
					video_start  = 1'b1;
					next_fails   = '0;
					next_lock    = 1'b1;
					next_dec_cnt = '0;
					next_state   = ST_VIDEO;
				end else begin
					next_lock = 1'b0;
					next_tmr  = '0;
					if (remote && fails == FAIL_END) begin
						serialization_enable_clr  = 1'b1;
						next_fails = '0;
						next_state = ST_CTRL;
					end else begin
						// local end keeps retrying forever
						next_fails    = remote ? fails + 1'b1 : '0;
						next_long_seq = 1'b1;
					end
				end
			end
			ST_VIDEO: begin
				if (decode_err_i && dec_cnt != 8'hFF) begin
					next_dec_cnt = dec_cnt + 1'b1;
				end
				if (word_valid_i) begin
					next_word_q = word_i;
				end
				if (!pclk_present_i) begin
					next_pll_ok = 1'b0;
					next_state  = ST_CTRL;
				end else if (vsync_edge_i) begin
					ch_open    = 1'b1;
					next_state = ST_CTRL;
				end
			end
		endcase
		next_control_phase_active = (next_state == ST_CTRL) || (next_state == ST_WAKE);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state    <= ST_BOOT;
			tmr      <= '0;
			fails    <= '0;
			remote   <= 1'b0;
			pll_ok   <= 1'b0;
			long_seq <= 1'b1;
			lock     <= 1'b0;
			lock_tx  <= 1'b0;
			control_phase_active     <= 1'b0;
			dec_cnt  <= '0;
			word_q   <= '0;
		end else begin
			state    <= next_state;
			tmr      <= next_tmr;
			fails    <= next_fails;
			remote   <= next_remote;
			pll_ok   <= next_pll_ok;
			long_seq <= next_long_seq;
			lock     <= next_lock;
			lock_tx  <= next_lock_tx;
			control_phase_active     <= next_control_phase_active;
			dec_cnt  <= next_dec_cnt;
			word_q   <= next_word_q;
		end
	end

	// host register writes only land while the channel is open in base mode
	assign wr_ok     = reg_wr_i && !bypass_mode_i &&
		(state == ST_CTRL || state == ST_WAKE);
	assign err_frame = closing_frame_i && (state == ST_CTRL) && !bypass_mode_i;

	always_comb begin
		next_cfg        = cfg;
		next_par_lim    = par_lim;
		next_par_cnt    = par_cnt;
		next_prbs_cnt   = prbs_cnt;
		next_lfsr       = lfsr;
		next_ser_err    = ser_err;
		next_uart_flags = uart_flags;
		next_par_flag   = par_flag;
		next_rdata      = rdata;
		if (wr_ok) begin
			unique case (reg_addr_i)
				REG_VIDEO_CFG: next_cfg.parity_en = reg_wdata_i[PARITY_EN_BIT];
				REG_ERR_CFG:
					next_cfg.auto_error_clear = reg_wdata_i[AUTO_CLR_BIT];
				REG_POWER: begin
					next_cfg.power_down_bit       = reg_wdata_i[POWER_DOWN_BIT];
					next_cfg.serialization_enable = reg_wdata_i[SER_EN_BIT];
					next_cfg.pattern_test_enable  = reg_wdata_i[PATTERN_EN_BIT];
				end
				REG_PAR_LIM_LO: next_par_lim[7:0]  = reg_wdata_i;
				REG_PAR_LIM_HI: next_par_lim[15:8] = reg_wdata_i;
				REG_RATE: next_cfg.pixel_rate_range = reg_wdata_i[1:0];
				default: next_cfg = cfg;
			endcase
		end
		if (boot_remote) begin
			next_cfg.serialization_enable = 1'b0;
			next_cfg.power_down_bit       = 1'b1;
		end
		if (serialization_enable_clr) begin
			next_cfg.serialization_enable = 1'b0;
		end
		// serializer side error capture, wiped when the next channel opens
		if (ch_open) begin
			next_ser_err = '0;
		end else if (state == ST_CTRL && !bypass_mode_i) begin
			next_ser_err = ser_err | {ser_uart_err_i[ERRF_W-1] & i2c_enable_i,
				ser_uart_err_i[ERRF_W-2:0]};
		end
		// clears first so a same-cycle set survives
		if (reg_rd_i && reg_addr_i == REG_UART_ERR) begin
			next_uart_flags = '0;
		end
		if (reg_rd_i && reg_addr_i == REG_PAR_CNT_LO) begin
			next_par_cnt[7:0] = '0;
		end
		if (reg_rd_i && reg_addr_i == REG_PAR_CNT_HI) begin
			next_par_cnt[15:8] = '0;
		end
		if (ch_end && cfg.auto_error_clear) begin
			next_uart_flags = '0;
			next_par_cnt    = '0;
		end
		if (err_frame) begin
			next_uart_flags = next_uart_flags |
				8'(ser_err | des_uart_err_i);
		end
		if (cfg.parity_en && parity_err_i && state == ST_VIDEO &&
			par_cnt != 16'hFFFF) begin
			next_par_cnt = next_par_cnt + 1'b1;
		end
		if (video_start) begin
			next_par_flag = 1'b0;
		end
		if (par_cnt >= par_lim && (!bypass_mode_i || cfg.auto_error_clear)) begin
			next_par_flag = 1'b1;
		end
		// prbs checker, untouched by auto clear
		if (!next_cfg.pattern_test_enable) begin
			next_prbs_cnt = '0;
			next_lfsr     = PRBS_SEED;
		end else if (state == ST_VIDEO && word_valid_i) begin
			next_lfsr = {lfsr[21:0], lfsr[22] ^ lfsr[17]};
			if (word_i != lfsr[WORD_W-1:0] && prbs_cnt != 8'hFF) begin
				next_prbs_cnt = prbs_cnt + 1'b1;
			end
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_VIDEO_CFG: next_rdata = 8'(cfg.parity_en) << PARITY_EN_BIT;
				REG_ERR_CFG:
					next_rdata = 8'(cfg.auto_error_clear) << AUTO_CLR_BIT;
				REG_POWER: next_rdata =
					(8'(cfg.power_down_bit) << POWER_DOWN_BIT) |
					(8'(cfg.serialization_enable) << SER_EN_BIT) |
					(8'(cfg.pattern_test_enable) << PATTERN_EN_BIT);
				REG_PAR_LIM_LO: next_rdata = par_lim[7:0];
				REG_PAR_LIM_HI: next_rdata = par_lim[15:8];
				REG_PAR_CNT_LO: next_rdata = par_cnt[7:0];
				REG_PAR_CNT_HI: next_rdata = par_cnt[15:8];
				REG_PRBS_CNT:   next_rdata = prbs_cnt;
				REG_UART_ERR:   next_rdata = uart_flags;
				REG_RATE:       next_rdata = 8'(cfg.pixel_rate_range);
				default:        next_rdata = 8'h00;
			endcase
		end
		// uart flags only count while the receiver is locked
		next_err_q = ((|next_uart_flags) && next_lock) ||
			next_par_flag || (next_prbs_cnt != 8'h00);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg        <= '{parity_en: 1'b0, auto_error_clear: 1'b0,
				power_down_bit: 1'b0, serialization_enable: 1'b1,
				pattern_test_enable: 1'b0, pixel_rate_range: 2'h0};
			par_lim    <= PAR_LIM_RST;
			par_cnt    <= '0;
			prbs_cnt   <= '0;
			lfsr       <= PRBS_SEED;
			ser_err    <= '0;
			uart_flags <= '0;
			par_flag   <= 1'b0;
			err_q      <= 1'b0;
			rdata      <= '0;
		end else begin
			cfg        <= next_cfg;
			par_lim    <= next_par_lim;
			par_cnt    <= next_par_cnt;
			prbs_cnt   <= next_prbs_cnt;
			lfsr       <= next_lfsr;
			ser_err    <= next_ser_err;
			uart_flags <= next_uart_flags;
			par_flag   <= next_par_flag;
			err_q      <= next_err_q;
			rdata      <= next_rdata;
		end
	end

	assign reg_rdata_o            = rdata;
	assign low_power_o            = state == ST_OFF;
	assign timers_enable_o        = cfg.serialization_enable;
	assign control_phase_active_o = control_phase_active;
	assign lock_oe_o              = !lock;
	assign lock_frame_tx_o        = lock_tx;
	assign sync_active_o          = state == ST_SYNC;
	assign sync_long_o            = long_seq;
	assign error_oe_o             = err_q;
	assign word_o                 = word_q;
endmodule
`default_nettype wire

/* File: tb/lpm_link_properties.sv */
// port assertions for the link manager
`timescale 1ns/1ps
`default_nettype none
module lpm_link_properties
	import lpm_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        pclk_present_i,
	input wire logic        dummy_frame_i,
	input wire logic        closing_frame_i,
	input wire logic        bypass_mode_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        low_power_o,
	input wire logic        timers_enable_o,
	input wire logic        control_phase_active_o,
	input wire logic        lock_oe_o,
	input wire logic        lock_frame_tx_o,
	input wire logic        sync_active_o,
	input wire logic        error_oe_o,
	input wire logic [17:0] word_o
);
	logic [14:0] sync_len;
	logic [14:0] next_sync_len;
	// length of the pattern just ended, held until the fall is seen
	always_comb next_sync_len = sync_active_o ? sync_len + 15'h1 : 15'h0;
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i) sync_len <= 15'h0;
		else sync_len <= next_sync_len;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sync_length_a: assert property ($fell(sync_active_o) |->
		sync_len inside {15'h222, 15'h442, 15'h4402}) else $error("bad sync length");
	power_down_a: assert property (reg_wr_i && reg_addr_i == REG_POWER
		&& reg_wdata_i[POWER_DOWN_BIT] && control_phase_active_o && !bypass_mode_i
		|-> ##[1:3] low_power_o) else $error("power down write ignored");
	stay_asleep_a: assert property (low_power_o && !dummy_frame_i |=>
		low_power_o) else $error("woke without wake frame");
	chan_hold_a: assert property (control_phase_active_o &&
		(!timers_enable_o || !pclk_present_i) |=> control_phase_active_o
		|| low_power_o) else $error("channel closed too early");
	lock_frame_a: assert property (lock_frame_tx_o |-> !lock_oe_o)
		else $error("lock frame sent while unlocked");
	word_hold_a: assert property (control_phase_active_o [*3] |->
		$stable(word_o)) else $error("data moved in channel");
	uart_reread_a: assert property (reg_rd_i && reg_addr_i == REG_UART_ERR
		&& !closing_frame_i ##1 !closing_frame_i ##1 reg_rd_i && !closing_frame_i
		&& reg_addr_i == REG_UART_ERR |=> reg_rdata_o == 8'h00)
		else $error("uart flags not cleared by read");
	prbs_flag_a: assert property (reg_rd_i && reg_addr_i == REG_PRBS_CNT
		|=> reg_rdata_o == 8'h00 || error_oe_o) else $error("prbs error not flagged");
	cover property ($fell(sync_active_o) && sync_len == 15'h222);
	cover property (lock_frame_tx_o);
	cover property ($rose(low_power_o));
endmodule
`default_nettype wire

/* File: tb/lpm_far_end.sv */
// far-end model: paired chip answering the lock frame
`timescale 1ns/1ps
`default_nettype none
module lpm_far_end #(
	parameter int unsigned DLY = 3
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic lock_frame_tx_i,
	output logic      lock_frame_rx_o,
	output logic      sync_ok_o
);
	logic [DLY-1:0] pipe;
	logic [DLY-1:0] next_pipe;
	// frame crosses the link some words later, not in the same cycle
	always_comb next_pipe = {pipe[DLY-2:0], lock_frame_tx_i};
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i) pipe <= {DLY{1'b0}};
		else pipe <= next_pipe;
	assign lock_frame_rx_o = pipe[DLY-1];
	// training always succeeds; retry limit is not exercised
	assign sync_ok_o = 1'b1;
endmodule
`default_nettype wire

/* File: tb/lpm_link_manager_bench.sv */
// bench: register access, link rounds and error output
`timescale 1ns/1ps
`default_nettype none
module lpm_link_manager_bench import lpm_pkg::*; ;
	logic        clk_i, arst_n_i, remote_wake_select_i, pclk_present_i;
	logic        dummy_frame_i, vsync_edge_i, chan_timeout_i, closing_frame_i;
	logic        bypass_mode_i, lock_frame_rx_i, sync_ok_i, decode_err_i;
	logic        i2c_enable_i, parity_err_i, word_valid_i, reg_wr_i, reg_rd_i;
	logic [3:0]  ser_uart_err_i, des_uart_err_i;
	logic [17:0] word_i, word_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic        low_power_o, timers_enable_o, control_phase_active_o;
	logic        lock_oe_o, lock_frame_tx_o, sync_active_o, sync_long_o;
	logic        error_oe_o;
	int          miscompares, checks_done, n;
	lpm_link_manager #(.WAKE_LIM(200), .PLLW_LIM(50)) uut (.*);
	lpm_far_end far (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.lock_frame_tx_i(lock_frame_tx_o), .lock_frame_rx_o(lock_frame_rx_i),
		.sync_ok_o(sync_ok_i));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		chk({10'h000, reg_rdata_o}, {10'h000, e});
		tick(1);
	endtask
	// s 0 watches the pattern flag, s 1 the channel flag; n counts cycles
	task automatic wait_for(input int s, input logic v, input int lim);
		for (n = 0; n <= lim; n++) begin
			if ((s == 0 ? sync_active_o : control_phase_active_o) === v)
				return;
			tick(1);
		end
		miscompares++;
		finish_test();
	endtask
	// one blanking round: open, one write, close, train, back to video
	task automatic chan(input logic [7:0] a, input logic [7:0] d, input int len);
		word_i = 18'h12345;
		vsync_edge_i = 1'b1;
		tick(1);
		vsync_edge_i = 1'b0;
		wait_for(1, 1'b1, 100);
		word_i = 18'h0ABCD;
		tick(2);
		if (len != LONG_LEN) chk(word_o, 18'h12345);
		wr(a, d);
		closing_frame_i = 1'b1;
		tick(1);
		closing_frame_i = 1'b0;
		wait_for(0, 1'b1, 400);
		if (len == LONG_LEN) chk(error_oe_o, 1'b0);
		chk(sync_long_o, len == LONG_LEN);
		wait_for(0, 1'b0, 20000);
		chk(n[17:0], len[17:0]);
		tick(3);
		chk(lock_oe_o, 1'b0);
		chk(control_phase_active_o, 1'b0);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		{arst_n_i, remote_wake_select_i, pclk_present_i, dummy_frame_i} = 4'h0;
		{vsync_edge_i, chan_timeout_i, closing_frame_i, bypass_mode_i} = 4'h0;
		{decode_err_i, i2c_enable_i, parity_err_i, reg_wr_i, reg_rd_i} = 5'h00;
		{ser_uart_err_i, des_uart_err_i, reg_addr_i, reg_wdata_i} = 24'h000000;
		word_valid_i = 1'b1;
		word_i = 18'h00000;
		miscompares = 0;
		checks_done = 0;
		tick(12);
		arst_n_i = 1'b1;
		tick(3);
		chk(control_phase_active_o, 1'b1);
		chk(timers_enable_o, 1'b1);
		chk(low_power_o, 1'b0);
		chk(lock_oe_o, 1'b1);
		rd(REG_PAR_LIM_LO, 8'hFF);
		rd(8'h20, 8'h00);
		wr(REG_PAR_LIM_LO, 8'h02);
		wr(REG_PAR_LIM_HI, 8'h00);
		wr(REG_VIDEO_CFG, 8'h08);
		chan_timeout_i = 1'b1;
		tick(1);
		chan_timeout_i = 1'b0;
		tick(2);
		chk(control_phase_active_o, 1'b1);
		ser_uart_err_i = 4'h1;
		tick(1);
		ser_uart_err_i = 4'h0;
		pclk_present_i = 1'b1;
		chan(REG_RATE, 8'h00, LONG_LEN);
		chk(error_oe_o, 1'b1);
		rd(REG_UART_ERR, 8'h01);
		chk(error_oe_o, 1'b0);
		rd(REG_UART_ERR, 8'h00);
		parity_err_i = 1'b1;
		tick(2);
		parity_err_i = 1'b0;
		tick(2);
		chk(error_oe_o, 1'b1);
		rd(REG_PAR_CNT_LO, 8'h02);
		rd(REG_PAR_CNT_HI, 8'h00);
		rd(REG_PAR_CNT_LO, 8'h00);
		chk(error_oe_o, 1'b1);
		parity_err_i = 1'b1;
		tick(1);
		parity_err_i = 1'b0;
		for (int r = 0; r < 4; r++)
			chan(REG_RATE, r[7:0], r < 2 ? SHORT_LEN_LO : SHORT_LEN_HI);
		chk(error_oe_o, 1'b0);
		rd(REG_PAR_CNT_LO, 8'h01);
		parity_err_i = 1'b1;
		tick(1);
		parity_err_i = 1'b0;
		chan(REG_ERR_CFG, 8'h20, SHORT_LEN_HI);
		rd(REG_PAR_CNT_LO, 8'h00);
		// fixed video word never matches the pattern, so every word counts
		chan(REG_POWER, 8'h09, SHORT_LEN_HI);
		chk(error_oe_o, 1'b1);
		rd(REG_PRBS_CNT, 8'h03);
		chan(REG_POWER, 8'h08, SHORT_LEN_HI);
		chk(error_oe_o, 1'b0);
		rd(REG_PRBS_CNT, 8'h00);
		arst_n_i = 1'b0;
		remote_wake_select_i = 1'b1;
		tick(12);
		arst_n_i = 1'b1;
		tick(20);
		chk(low_power_o, 1'b1);
		dummy_frame_i = 1'b1;
		tick(1);
		dummy_frame_i = 1'b0;
		tick(2);
		chk(low_power_o, 1'b0);
		tick(210);
		chk(low_power_o, 1'b1);
		dummy_frame_i = 1'b1;
		tick(1);
		dummy_frame_i = 1'b0;
		// settle wait scaled down with the shortened wake window
		tick(5);
		wr(REG_POWER, 8'h00);
		wait_for(1, 1'b1, 50);
		wr(REG_POWER, 8'h00);
		closing_frame_i = 1'b1;
		tick(1);
		closing_frame_i = 1'b0;
		tick(250);
		chk(timers_enable_o, 1'b0);
		chk(control_phase_active_o, 1'b1);
		wr(REG_POWER, 8'h08);
		chk(timers_enable_o, 1'b1);
		wr(REG_POWER, 8'h18);
		tick(2);
		chk(low_power_o, 1'b1);
		finish_test();
	end
endmodule
bind lpm_link_manager lpm_link_properties chk (.*);
`default_nettype wire
